// [shared/gpt_pkg.sv]
// Purpose: Constants for the sixteen-bit general purpose timer.
// Assumes: Avalon-MM slave with 32-bit data, one word per register.
// Notes: Offsets are byte addresses.
package gpt_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hC;
   localparam int BIT_ON = 15;
   localparam int BIT_SIDL = 13;
   localparam int BIT_GATE = 6;
   localparam int BIT_PS_HI = 5;
   localparam int BIT_PS_LO = 4;
   localparam int BIT_SYNC = 2;
   localparam int BIT_CS = 1;
   localparam int BIT_FLAG = 0;
   localparam int BIT_IE = 1;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] CONTROL_MASK = 16'hA076;
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV8 = 2'h1;
   localparam logic [1:0] PS_DIV64 = 2'h2;
   localparam logic [7:0] PS_MAX8 = 8'h07;
   localparam logic [7:0] PS_MAX64 = 8'h3F;
   localparam logic [7:0] PS_MAX256 = 8'hFF;
   typedef enum logic [1:0] {
      GPT_SRC_INT = 2'b00,
      GPT_SRC_GATED = 2'b01,
      GPT_SRC_SYNC = 2'b10,
      GPT_SRC_ASYNC = 2'b11
   } gpt_src_t;
endpackage

// [logic/gpt_timer.sv]
// Purpose: Sixteen-bit timer/counter with prescaler, period match and gated accumulation.
// Assumes: One clock; each clk edge is one instruction cycle; pins are synchronous to clk.
// Notes: Notes on behaviour follow.
//
// Notes on behaviour
// - Internal mode counts instruction cycles, clears on period match, keeps counting.
// - Internal, synchronous and gated modes pause in Idle when stop_in_idle set.
// - Synchronous counter counts synchronised external rising edges up to period, wraps.
// - Asynchronous counter counts every external rising edge up to period, wraps.
// - Asynchronous counter pauses in Idle when stop_in_idle set.
// - Gated mode counts instruction cycles while the gate pin is high.
// - Gated mode sets the interrupt flag on the gate falling edge.
// - Prescaler divides by 1, 8, 64 or 256 from prescale_select.
// - Prescaler clears on count write while timer_on is set, on timer_on clear, and on device reset.
// - With timer_on low the prescaler is halted; only device reset clears it.
// - Control writes leave the count; only count writes change it.
// - In Sleep only enabled external asynchronous counting continues, wrapping at period.
// - Period match sets the flag; interrupt only when enabled, also in Sleep.
// - The flag stays set until software clears it.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer
   import gpt_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Avalon-MM slave.
   input wire logic [gpt_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // Pins and power state.
   input wire logic external_clock_gate_pin,
   input wire logic cpu_idle,
   input wire logic cpu_sleep,
   // Interrupt.
   output logic irq
);
   import gpt_pkg::*;

   // ************************************************
   // Register state.
   // ************************************************
   logic [15:0] count_q, count_d;
   logic [15:0] period_q, period_d;
   logic [15:0] ctrl_q, ctrl_d;
   logic flag_q, flag_d;
   logic ie_q, ie_d;
   logic [7:0] ps_q, ps_d;
   logic pin_q, pin_d;
   logic pin_s1_q, pin_s2_q, pin_s3_q;
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] resp_q, resp_d;

   function automatic logic [7:0] ps_limit(input logic [1:0] sel);
      case (sel)
         PS_DIV1: ps_limit = 8'h00;
         PS_DIV8: ps_limit = PS_MAX8;
         PS_DIV64: ps_limit = PS_MAX64;
         default: ps_limit = PS_MAX256;
      endcase
   endfunction

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
      hit = (a == o);
   endfunction

   // ************************************************
   // Mode decode and prescaler.
   // ************************************************
   logic t_on, sidl, gate_en, cs, sync_sel;
   gpt_src_t src;
   logic sync_edge, async_edge, gate_fall, tick_in, run_ok, ps_tick, match;
   logic bus_req, wr_acc, wr_count, wr_ctrl, wr_period, wr_status;

   assign t_on = ctrl_q[BIT_ON];
   assign sidl = ctrl_q[BIT_SIDL];
   assign gate_en = ctrl_q[BIT_GATE];
   assign cs = ctrl_q[BIT_CS];
   assign sync_sel = ctrl_q[BIT_SYNC];
   assign src = !cs ? (gate_en ? GPT_SRC_GATED : GPT_SRC_INT)
              : (sync_sel ? GPT_SRC_SYNC : GPT_SRC_ASYNC);
   assign sync_edge = pin_s2_q & ~pin_s3_q;
   assign async_edge = external_clock_gate_pin & ~pin_q;
   assign gate_fall = pin_s3_q & ~pin_s2_q;
   assign bus_req = (avs_read | avs_write) & ~ack_q;
   // Writes land at the edge that ends the wait, where the master sees the answer.
   assign wr_acc = avs_write & ack_q;
   assign wr_count = wr_acc & hit(avs_address, OFS_COUNT);
   assign wr_period = wr_acc & hit(avs_address, OFS_PERIOD);
   assign wr_ctrl = wr_acc & hit(avs_address, OFS_CONTROL);
   assign wr_status = wr_acc & hit(avs_address, OFS_STATUS);

   always_comb begin
      case (src)
         GPT_SRC_INT: tick_in = 1'b1;
         GPT_SRC_GATED: tick_in = pin_s2_q;
         GPT_SRC_SYNC: tick_in = sync_edge;
         GPT_SRC_ASYNC: tick_in = async_edge;
         default: tick_in = 1'b0;
      endcase
      // Idle and Sleep gating.
      run_ok = t_on & ~(cpu_idle & sidl);
      if (cpu_sleep && src != GPT_SRC_ASYNC) begin
         run_ok = 1'b0;
      end
      ps_tick = run_ok & tick_in & (ps_q == ps_limit(ctrl_q[BIT_PS_HI:BIT_PS_LO]));
      match = (count_q == period_q);
   end

   // ************************************************
   // Counter, prescaler and flag next state.
   // ************************************************
   always_comb begin
      count_d = count_q;
      ps_d = ps_q;
      pin_d = external_clock_gate_pin;
      period_d = period_q;
      ctrl_d = ctrl_q;
      flag_d = flag_q;
      ie_d = ie_q;
      if (t_on && run_ok && tick_in) begin
         ps_d = ps_tick ? 8'h00 : ps_q + 8'h01;
      end
      if (ps_tick) begin
         count_d = match ? COUNT_RST : count_q + 16'h0001;
      end
      if (t_on && wr_count) begin
         ps_d = 8'h00;
      end
      if (wr_count) begin
         if (avs_byteenable[0]) count_d[7:0] = avs_writedata[7:0];
         if (avs_byteenable[1]) count_d[15:8] = avs_writedata[15:8];
      end
      if (wr_period) begin
         if (avs_byteenable[0]) period_d[7:0] = avs_writedata[7:0];
         if (avs_byteenable[1]) period_d[15:8] = avs_writedata[15:8];
      end
      if (wr_ctrl) begin
         if (avs_byteenable[0]) ctrl_d[7:0] = avs_writedata[7:0] & CONTROL_MASK[7:0];
         if (avs_byteenable[1]) ctrl_d[15:8] = avs_writedata[15:8] & CONTROL_MASK[15:8];
         if (t_on && !ctrl_d[BIT_ON]) ps_d = 8'h00;
      end
      if (wr_status && avs_byteenable[0]) begin
         if (avs_writedata[BIT_FLAG]) flag_d = 1'b0;
         ie_d = avs_writedata[BIT_IE];
      end
      if ((ps_tick && match) || (src == GPT_SRC_GATED && t_on && gate_fall)) begin
         flag_d = 1'b1;
      end
   end

   // ************************************************
   // Bus answer next state.
   // ************************************************
   always_comb begin
      ack_d = bus_req;
      rdata_d = 32'h0000_0000;
      resp_d = 2'h0;
      if (bus_req) begin
         case (avs_address)
            OFS_COUNT: rdata_d = {16'h0000, count_q};
            OFS_PERIOD: rdata_d = {16'h0000, period_q};
            OFS_CONTROL: rdata_d = {16'h0000, ctrl_q};
            OFS_STATUS: rdata_d = {30'h0000_0000, ie_q, flag_q};
            default: resp_d = 2'h2;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      pin_s1_q <= external_clock_gate_pin;
      pin_s2_q <= pin_s1_q;
      if (!rst_n) begin
         count_q <= COUNT_RST;
         period_q <= PERIOD_RST;
         ctrl_q <= CONTROL_RST;
         flag_q <= 1'b0;
         ie_q <= 1'b0;
         ps_q <= 8'h00;
         pin_q <= 1'b0;
         pin_s3_q <= 1'b0;
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         resp_q <= 2'h0;
      end else begin
         count_q <= count_d;
         period_q <= period_d;
         ctrl_q <= ctrl_d;
         flag_q <= flag_d;
         ie_q <= ie_d;
         ps_q <= ps_d;
         pin_q <= pin_d;
         pin_s3_q <= pin_s2_q;
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         resp_q <= resp_d;
      end
   end

   assign avs_waitrequest = ~ack_q;
   assign avs_readdata = rdata_q;
   assign avs_response = resp_q;
   assign irq = flag_q & ie_q;

   // ************************************************
   // Checks.
   // ************************************************
   wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ps_tick && match && !wr_count) |=> count_q == 16'h0000)
      else $error("count did not wrap on period match");
   idle_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_idle && sidl && !wr_count) |=> $stable(count_q))
      else $error("count moved while idle");
   off_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!t_on && !wr_count) |=> $stable(count_q) && $stable(ps_q))
      else $error("timer moved while off");
   ps_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (t_on && wr_count) |=> ps_q == 8'h00)
      else $error("prescaler not cleared on count write");
   ctrl_count_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ctrl && !ps_tick) |=> $stable(count_q))
      else $error("control write changed count");
   flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
      (flag_q && !wr_status) |=> flag_q)
      else $error("flag cleared without software");
   gate_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      (src == GPT_SRC_GATED && t_on && gate_fall) |=> flag_q)
      else $error("gate fall did not set flag");
   sleep_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_sleep && src != GPT_SRC_ASYNC && !wr_count) |=> $stable(count_q))
      else $error("count moved in sleep");
   irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      irq == (flag_q && ie_q))
      else $error("irq not gated by enable");
   div_eight_a: assert property (@(posedge clk) disable iff (!rst_n)
      ps_tick && ctrl_q[BIT_PS_HI:BIT_PS_LO] == PS_DIV8 |-> ps_q == 8'h07)
      else $error("divide by eight wrong");

   // ************************************************
   // Register access and counting checks.
   // ************************************************
   count_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_count && avs_byteenable[1:0] == 2'h3) |=> count_q == $past(avs_writedata[15:0]))
      else $error("count write not stored");

   ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ctrl && avs_byteenable[1:0] == 2'h3) |=> ctrl_q == ($past(avs_writedata[15:0]) & CONTROL_MASK))
      else $error("control write not stored");

   count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ps_tick && !match && !wr_count) |=> count_q == $past(count_q) + 16'h0001)
      else $error("count did not step on tick");

   count_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!ps_tick && !wr_count) |=> $stable(count_q))
      else $error("count moved without tick");

   match_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ps_tick && match) |=> flag_q)
      else $error("period match did not set flag");

   flag_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_status && avs_byteenable[0] && avs_writedata[BIT_FLAG] && !(ps_tick && match)
       && !(src == GPT_SRC_GATED && t_on && gate_fall)) |=> !flag_q)
      else $error("flag not cleared by software");

   ps_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_ctrl && t_on && avs_byteenable[1] && !avs_writedata[BIT_ON]) |=> ps_q == 8'h00)
      else $error("prescaler not cleared on stop");

   ps_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
      (!t_on && wr_count) |=> $stable(ps_q))
      else $error("halted prescaler changed");

   gate_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (src == GPT_SRC_GATED && !pin_s2_q && !wr_count) |=> $stable(count_q))
      else $error("gated count moved with gate low");

   async_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (src == GPT_SRC_ASYNC && cpu_idle && sidl && !wr_count) |=> $stable(count_q))
      else $error("async count moved while idle");

   sleep_run_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_sleep && src == GPT_SRC_ASYNC && t_on && !(cpu_idle && sidl)) |-> run_ok)
      else $error("async count stopped in sleep");

   ctrl_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ctrl_q & ~CONTROL_MASK) == 16'h0000)
      else $error("unused control bit set");

   wait_answer_a: assert property (@(posedge clk) disable iff (!rst_n)
      bus_req |=> !avs_waitrequest)
      else $error("bus answer late");

   wait_single_a: assert property (@(posedge clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("bus answer stood too long");

   irq_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (cpu_sleep && flag_q && ie_q) |-> irq)
      else $error("interrupt lost in sleep");

   resp_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_req && avs_address == OFS_COUNT) |=> avs_response == 2'h0)
      else $error("count access answered with error");
endmodule
`default_nettype wire

// [dv/gpt_pin_src.sv]
// Purpose: External clock and gate source for the timer pin.
// Assumes: Levels change just after rising clk edges.
// Notes: The pin idles low between bursts.
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_src (
   // Clock.
   input wire logic clk,
   // Pin.
   output logic pin
);
   initial begin
      pin = 1'b0;
   end
   // Each level is held for hi cycles, two or more for the synchroniser.
   task automatic pulse(input int n, input int hi);
      for (int i = 0; i < n; i++) begin
         pin <= 1'b1;
         repeat (hi) @(posedge clk);
         pin <= 1'b0;
         repeat (hi) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// [dv/gp_sixteen_bit_timer_tb.sv]
// Purpose: Self-checking bench for the timer.
// Assumes: One word per register, low half used.
// Notes: Counts over a run are checked within a small window.
`timescale 1ns/1ps
`default_nettype none
module gp_sixteen_bit_timer_tb;
   import gpt_pkg::*;
   // ****************************
   // Signals and tasks.
   // ****************************
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic [1:0] resp;
   logic pin;
   logic cpu_idle = 1'b0;
   logic cpu_sleep = 1'b0;
   logic irq;
   logic [15:0] q;
   logic [15:0] c;
   int errors = 0;
   int tests_run = 0;
   localparam logic [15:0] ON = 16'h8000;
   localparam logic [15:0] SIDL = 16'h2000;
   localparam logic [15:0] GATE = 16'h0040;
   localparam logic [15:0] SYNC = 16'h0004;
   localparam logic [15:0] CS = 16'h0002;
   localparam logic [15:0] RSTV [4] = '{COUNT_RST, PERIOD_RST, CONTROL_RST, 16'h0000};
   localparam int SH [4] = '{0, 3, 6, 8};
   always #10 clk = ~clk;
   gpt_timer gpt_timer_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .external_clock_gate_pin(pin), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
   gpt_pin_src gpt_pin_src_i (.clk(clk), .pin(pin));
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input logic [15:0] g);
      tests_run++;
      if ($isunknown(g) || g < lo || g > hi) begin
         errors++;
         $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      r = avs_readdata[15:0];
      resp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         errors++;
         give_verdict();
      end
      @(posedge clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] r);
      bus(a, 1'b0, 16'h0000, r);
   endtask
   // ****************************
   // Main sequence.
   // ****************************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         rd(4'(i * 4), q);
         chk("reset value", RSTV[i], q);
      end
      rd(4'h2, q);
      chk("unmapped response", 16'h0002, {14'h0, resp});
      wr(OFS_PERIOD, 16'h0005);
      wr(OFS_STATUS, 16'h0002);
      wr(OFS_CONTROL, ON);
      for (int i = 0; i < 30 && irq !== 1'b1; i++) @(posedge clk);
      chk("irq on match", 16'h0001, {15'h0, irq});
      repeat (3) begin
         rd(OFS_COUNT, q);
         rng("count wraps", 0, 5, q);
      end
      rd(OFS_STATUS, q);
      chk("flag held", 16'h0003, q);
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_STATUS, 16'h0003);
      rd(OFS_STATUS, q);
      chk("flag cleared", 16'h0002, q);
      chk("irq low", 16'h0000, {15'h0, irq});
      rd(OFS_COUNT, c);
      wr(OFS_CONTROL, {10'h0, PS_DIV64, 4'h0});
      rd(OFS_COUNT, q);
      chk("control write keeps count", c, q);
      wr(OFS_COUNT, 16'h0003);
      rd(OFS_COUNT, q);
      chk("count write", 16'h0003, q);
      wr(OFS_PERIOD, 16'hFFFF);
      for (int p = 0; p < 4; p++) begin
         wr(OFS_CONTROL, 16'h0000);
         wr(OFS_COUNT, 16'h0000);
         wr(OFS_CONTROL, ON | 16'(p << 4));
         repeat (1024) @(posedge clk);
         wr(OFS_CONTROL, 16'(p << 4));
         rd(OFS_COUNT, q);
         rng("prescale", 1024 >> SH[p], (1024 >> SH[p]) + 3, q);
      end
      wr(OFS_COUNT, 16'h0000);
      wr(OFS_CONTROL, ON | CS);
      gpt_pin_src_i.pulse(10, 1);
      repeat (4) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("async count", 16'h000A, q);
      wr(OFS_COUNT, 16'h0000);
      wr(OFS_CONTROL, ON | CS | SYNC);
      gpt_pin_src_i.pulse(10, 3);
      repeat (6) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("sync count", 16'h000A, q);
      cpu_sleep <= 1'b1;
      wr(OFS_CONTROL, ON | CS);
      wr(OFS_COUNT, 16'h0000);
      gpt_pin_src_i.pulse(7, 2);
      repeat (4) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("sleep async", 16'h0007, q);
      wr(OFS_CONTROL, ON);
      rd(OFS_COUNT, c);
      repeat (30) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("sleep internal", c, q);
      cpu_sleep <= 1'b0;
      cpu_idle <= 1'b1;
      wr(OFS_CONTROL, ON | SIDL);
      rd(OFS_COUNT, c);
      repeat (30) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("idle stop", c, q);
      wr(OFS_CONTROL, ON | SIDL | CS);
      gpt_pin_src_i.pulse(5, 2);
      rd(OFS_COUNT, q);
      chk("idle async stop", c, q);
      wr(OFS_CONTROL, ON);
      repeat (30) @(posedge clk);
      rd(OFS_COUNT, q);
      rng("idle run", int'(c) + 30, int'(c) + 40, q);
      cpu_idle <= 1'b0;
      wr(OFS_CONTROL, 16'h0000);
      wr(OFS_COUNT, 16'h0000);
      wr(OFS_CONTROL, ON | GATE);
      repeat (20) @(posedge clk);
      rd(OFS_COUNT, q);
      chk("gate low", 16'h0000, q);
      rd(OFS_STATUS, q);
      chk("flag before fall", 16'h0002, q);
      gpt_pin_src_i.pulse(1, 10);
      repeat (5) @(posedge clk);
      rd(OFS_COUNT, q);
      rng("gated count", 9, 11, q);
      rd(OFS_STATUS, q);
      chk("gate fall flag", 16'h0003, q);
      give_verdict();
   end
endmodule
`default_nettype wire
